// File: core/clkdist_pkg.sv
package clkdist_pkg;

    // =====================================================================
    // Modes, reference sources, PLL states and configuration
    // =====================================================================
    typedef enum logic [2:0]
    {
        MODE_BASIC = 3'h0,
        MODE_PIPE  = 3'h1,
        MODE_GIGE  = 3'h2,
        MODE_XAUI  = 3'h3,
        MODE_SDI   = 3'h4
    } func_mode_e;

    typedef enum logic [1:0]
    {
        REF_PIN_A  = 2'h0,
        REF_PIN_B  = 2'h1,
        REF_FABRIC = 2'h2,
        REF_INTER  = 2'h3
    } ref_src_e;

    typedef enum logic [1:0]
    {
        PLL_IDLE = 2'h0,
        PLL_ACQ  = 2'h1,
        PLL_LOCK = 2'h2
    } pll_state_e;

    typedef struct packed
    {
        func_mode_e mode;
        ref_src_e   ref_src;
        logic       inter_idx;
        logic       fwd_core;
    } clk_cfg_s;

    // =====================================================================
    // Sizes and counts
    // =====================================================================
    localparam int NUM_RX_PLL      = 4;
    localparam int NUM_INTER       = 2;
    localparam int MAX_GLOBAL      = 16;
    localparam int MAX_REGIONAL    = 16;
    localparam int MAX_ROUTE_PATHS = 8;
    localparam int DIV_W           = 4;
    localparam int CNT_W           = 5;
    localparam logic [DIV_W-1:0] LOCK_EDGES = 4'h8;
    localparam logic [DIV_W-1:0] RATIO_WIDE = 4'ha;
    localparam logic [DIV_W-1:0] RATIO_BYTE = 4'h5;

    // =====================================================================
    // Mode decoding
    // =====================================================================
    function automatic logic uses_byte_ser(input func_mode_e m);
        return (m == MODE_PIPE) || (m == MODE_XAUI);
    endfunction : uses_byte_ser

    function automatic logic uses_rate_match(input func_mode_e m);
        return (m == MODE_PIPE) || (m == MODE_GIGE) || (m == MODE_XAUI);
    endfunction : uses_rate_match

    function automatic logic [DIV_W-1:0] div_ratio(input func_mode_e m);
        return uses_byte_ser(m) ? RATIO_BYTE : RATIO_WIDE;
    endfunction : div_ratio

endpackage : clkdist_pkg

// File: core/transceiver_clock_distribution.sv
`timescale 1ns/1ps
module transceiver_clock_distribution #(
    parameter int NUM_CH = clkdist_pkg::NUM_RX_PLL
) (
    // Clock, reset, enable
    input  wire logic                  clk_i,
    input  wire logic                  srst_i,
    input  wire logic                  ce_i,
    // Static configuration
    input  wire clkdist_pkg::clk_cfg_s cfg_i,
    // Reference clock sources
    input  wire logic                  dedicated_ref_pin_a_i,
    input  wire logic                  dedicated_ref_pin_b_i,
    input  wire logic                  fabric_ref_i,
    input  wire logic [1:0]            inter_ref_i,
    // Receive data transitions and fixed clock
    input  wire logic [NUM_CH-1:0]     rx_transition_i,
    input  wire logic                  fixedclk_i,
    // Transmit clocks
    output logic                       tx_pll_locked_o,
    output logic                       tx_serial_clk_o,
    output logic                       tx_pcs_clk_en_o,
    output logic                       tx_clkout_o,
    output logic                       core_clkout_o,
    // Receive clocks
    output logic [NUM_CH-1:0]          rx_pll_locked_o,
    output logic [NUM_CH-1:0]          rx_front_clk_en_o,
    output logic [NUM_CH-1:0]          rx_back_clk_en_o,
    output logic [NUM_CH-1:0]          rx_clkout_o,
    output logic                       rx_detect_clk_o,
    // Clock resource accounting and configuration change flag
    output logic [clkdist_pkg::CNT_W-1:0] route_paths_o,
    output logic                       route_overflow_o,
    output logic                       cfg_change_o
);

    // =====================================================================
    // Configuration capture
    // =====================================================================
    // The configuration is only sampled while reset is held, so a change
    // during traffic can never retime a running clock; it is just flagged.
    clkdist_pkg::clk_cfg_s cfg_reg, cfg_next;
    logic                  chg_reg, chg_next;
    logic                  byte_ser, rate_match;
    logic [clkdist_pkg::DIV_W-1:0] ratio;

    assign byte_ser   = clkdist_pkg::uses_byte_ser(cfg_reg.mode);
    assign rate_match = clkdist_pkg::uses_rate_match(cfg_reg.mode);
    assign ratio      = clkdist_pkg::div_ratio(cfg_reg.mode);

    always_comb
    begin
        cfg_next = cfg_reg;
        chg_next = chg_reg;
        if (srst_i)
        begin
            cfg_next = cfg_i;
            chg_next = 1'b0;
        end
        else if (cfg_i != cfg_reg)
        begin
            chg_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (ce_i || srst_i)
        begin
            cfg_reg <= cfg_next;
            chg_reg <= chg_next;
        end
    end

    // =====================================================================
    // Reference selection
    // =====================================================================
    logic ref_sel, ref_prev_reg, ref_rise;

    always_comb
    begin
        case (cfg_reg.ref_src)
            clkdist_pkg::REF_PIN_A:  ref_sel = dedicated_ref_pin_a_i;
            clkdist_pkg::REF_PIN_B:  ref_sel = dedicated_ref_pin_b_i;
            clkdist_pkg::REF_FABRIC: ref_sel = fabric_ref_i;
            default:                 ref_sel = inter_ref_i[cfg_reg.inter_idx];
        endcase
    end

    assign ref_rise = ref_sel & ~ref_prev_reg;

    // =====================================================================
    // Transmit PLL and divider
    // =====================================================================
    clkdist_pkg::pll_state_e st_reg, st_next;
    logic [clkdist_pkg::DIV_W-1:0] lock_reg, lock_next;
    logic [clkdist_pkg::DIV_W-1:0] div_reg, div_next;
    logic ser_reg, ser_next, half_reg, half_next;
    logic tick_reg, tick_next, lvl_reg, lvl_next;
    logic ser_rise, div_in;

    assign ser_rise = (st_reg == clkdist_pkg::PLL_LOCK) & ~ser_reg;
    assign div_in   = byte_ser ? (ser_rise & half_reg) : ser_rise;

    always_comb
    begin
        st_next   = st_reg;
        lock_next = lock_reg;
        ser_next  = 1'b0;
        half_next = half_reg;
        div_next  = div_reg;
        tick_next = 1'b0;
        lvl_next  = lvl_reg;
        case (st_reg)
            clkdist_pkg::PLL_IDLE:
            begin
                st_next   = clkdist_pkg::PLL_ACQ;
                lock_next = '0;
            end
            clkdist_pkg::PLL_ACQ:
            begin
                if (ref_rise)
                begin
                    lock_next = lock_reg + 4'h1;
                    if (lock_reg == clkdist_pkg::LOCK_EDGES - 4'h1)
                    begin
                        st_next = clkdist_pkg::PLL_LOCK;
                    end
                end
            end
            clkdist_pkg::PLL_LOCK:
            begin
                // One serial period spans two system cycles: each period
                // carries two line bits, one on each edge.
                ser_next = ~ser_reg;
            end
            default:
            begin
                st_next = clkdist_pkg::PLL_IDLE;
            end
        endcase
        if (ser_rise)
        begin
            half_next = ~half_reg;
        end
        if (div_in)
        begin
            if (div_reg == ratio - 4'h1)
            begin
                div_next  = '0;
                tick_next = 1'b1;
            end
            else
            begin
                div_next = div_reg + 4'h1;
            end
            lvl_next = (div_next < (ratio >> 1)) ? 1'b1 : 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            st_reg       <= clkdist_pkg::PLL_IDLE;
            lock_reg     <= '0;
            ser_reg      <= 1'b0;
            half_reg     <= 1'b0;
            div_reg      <= '0;
            tick_reg     <= 1'b0;
            lvl_reg      <= 1'b0;
            ref_prev_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            st_reg       <= st_next;
            lock_reg     <= lock_next;
            ser_reg      <= ser_next;
            half_reg     <= half_next;
            div_reg      <= div_next;
            tick_reg     <= tick_next;
            lvl_reg      <= lvl_next;
            ref_prev_reg <= ref_sel;
        end
    end

    assign tx_pll_locked_o = (st_reg == clkdist_pkg::PLL_LOCK);
    assign tx_serial_clk_o = ser_reg;
    assign tx_pcs_clk_en_o = tick_reg;
    assign tx_clkout_o     = cfg_reg.fwd_core ? 1'b0 : lvl_reg;
    assign core_clkout_o   = cfg_reg.fwd_core ? lvl_reg : 1'b0;

    fwd_select_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !(tx_clkout_o && core_clkout_o))
        else $error("parallel clock driven on both outputs");

    byte_half_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (byte_ser && div_in) |=> !div_in [*3])
        else $error("halved serial clock ticks too often");

    lock_edges_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (st_reg != clkdist_pkg::PLL_LOCK) |-> !ser_reg && !tick_reg)
        else $error("serial clock runs before lock");

    // =====================================================================
    // Receive PLLs and clock recovery
    // =====================================================================
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++)
        begin : g_rx
            logic [clkdist_pkg::DIV_W-1:0] rl_reg, rl_next, rc_reg, rc_next;
            logic locked, rp_reg, rp_next, rv_reg, rv_next;

            assign locked = (rl_reg == clkdist_pkg::LOCK_EDGES);

            always_comb
            begin
                rl_next = rl_reg;
                rc_next = rc_reg;
                rp_next = 1'b0;
                rv_next = rv_reg;
                if (!locked && ref_rise)
                begin
                    rl_next = rl_reg + 4'h1;
                end
                if (locked && rx_transition_i[ch])
                begin
                    if (rc_reg == ratio - 4'h1)
                    begin
                        rc_next = '0;
                        rp_next = 1'b1;
                    end
                    else
                    begin
                        rc_next = rc_reg + 4'h1;
                    end
                    rv_next = (rc_next < (ratio >> 1)) ? 1'b1 : 1'b0;
                end
            end

            always_ff @(posedge clk_i)
            begin
                if (srst_i)
                begin
                    rl_reg <= '0;
                    rc_reg <= '0;
                    rp_reg <= 1'b0;
                    rv_reg <= 1'b0;
                end
                else if (ce_i)
                begin
                    rl_reg <= rl_next;
                    rc_reg <= rc_next;
                    rp_reg <= rp_next;
                    rv_reg <= rv_next;
                end
            end

            assign rx_pll_locked_o[ch]   = locked;
            assign rx_front_clk_en_o[ch] = rp_reg;
            assign rx_back_clk_en_o[ch]  = rate_match ? tick_reg : rp_reg;
            assign rx_clkout_o[ch]       = rate_match ? 1'b0 : rv_reg;

            rx_back_a: assert property (@(posedge clk_i) disable iff (srst_i)
                rate_match |-> (rx_back_clk_en_o[ch] == tx_pcs_clk_en_o))
                else $error("receive back end not on divider clock");

            rx_norm_a: assert property (@(posedge clk_i) disable iff (srst_i)
                !rate_match |-> (rx_back_clk_en_o[ch] == rp_reg))
                else $error("receive back end not on recovered clock");

            rx_fabric_a: assert property (@(posedge clk_i) disable iff (srst_i)
                rate_match |-> !rx_clkout_o[ch])
                else $error("recovered clock exported with rate matcher");
        end
    endgenerate

    // =====================================================================
    // Fixed clock and clock resource accounting
    // =====================================================================
    localparam int CNT_W = clkdist_pkg::CNT_W;
    logic [clkdist_pkg::CNT_W-1:0] paths_reg, paths_next;
    logic                          ovf_reg, ovf_next;

    assign rx_detect_clk_o = (cfg_reg.mode == clkdist_pkg::MODE_PIPE)
                           ? fixedclk_i : 1'b0;

    // Counted: forwarded transmit clock, calibration clock, exported
    // recovered clocks, a fabric reference and the fixed clock.
    always_comb
    begin
        paths_next = 5'h2;
        if (!rate_match)
        begin
            paths_next = paths_next + CNT_W'(NUM_CH);
        end
        if (cfg_reg.ref_src == clkdist_pkg::REF_FABRIC)
        begin
            paths_next = paths_next + 5'h1;
        end
        if (cfg_reg.mode == clkdist_pkg::MODE_PIPE)
        begin
            paths_next = paths_next + 5'h1;
        end
        ovf_next = (paths_next > CNT_W'(clkdist_pkg::MAX_ROUTE_PATHS)) ||
                   (paths_next > CNT_W'(clkdist_pkg::MAX_GLOBAL));
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            paths_reg <= '0;
            ovf_reg   <= 1'b0;
        end
        else if (ce_i)
        begin
            paths_reg <= paths_next;
            ovf_reg   <= ovf_next;
        end
    end

    assign route_paths_o    = paths_reg;
    assign route_overflow_o = ovf_reg;
    assign cfg_change_o     = chg_reg;

    fixed_gate_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (cfg_reg.mode != clkdist_pkg::MODE_PIPE) |-> !rx_detect_clk_o)
        else $error("fixed clock leaks outside PIPE mode");

    route_limit_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (ce_i && $past(ce_i) && !$past(srst_i)) |->
        (route_overflow_o == (route_paths_o > 5'h8)))
        else $error("route overflow flag wrong");

    cfg_static_a: assert property (@(posedge clk_i) disable iff (srst_i)
        $past(!srst_i) |-> $stable(cfg_reg))
        else $error("configuration changed outside reset");

endmodule : transceiver_clock_distribution

// File: verif/fabric_model.sv
`timescale 1ns/1ps
// ==========
// Fabric side
// ==========
module fabric_model (
    // Clock and reset
    input  wire logic  clk_i,
    input  wire logic  srst_i,
    // Clocks toward the block
    output logic       ref_a_o = 1'b0,
    output logic       ref_b_o = 1'b0,
    output logic       fabric_ref_o = 1'b0,
    output logic [1:0] inter_ref_o = 2'h0,
    output logic [3:0] rx_transition_o = 4'h0,
    output logic       fixedclk_o = 1'b0
);
    int unsigned cyc_reg = 0;

    function automatic logic wave(input int unsigned c, input int unsigned p);
        return (c % p) >= (p / 2);
    endfunction : wave

    // Six clocks at most enter the block, so its eight paths never run out.
    always @(posedge clk_i)
    begin
        cyc_reg <= srst_i ? 0 : cyc_reg + 1;
        ref_a_o <= wave(cyc_reg, 2);
        ref_b_o <= wave(cyc_reg, 4);
        // The network copy is a plain pin clock, never gated by logic.
        fabric_ref_o <= wave(cyc_reg, 6);
        inter_ref_o <= {wave(cyc_reg, 10), wave(cyc_reg, 8)};
        fixedclk_o <= wave(cyc_reg, 4);
        // Channel k sees a bit every k+1 cycles, so channel 3 is the slow one.
        for (int k = 0; k < 4; k++)
            rx_transition_o[k] <= (cyc_reg % (k + 1)) == 0;
    end
endmodule : fabric_model

// File: verif/test_transceiver_clock_distribution.sv
`timescale 1ns/1ps
module test_transceiver_clock_distribution;
    // ==========
    // Signals
    // ==========
    logic                  clk_i = 1'b0;
    logic                  srst_i = 1'b1;
    logic                  ce_i = 1'b1;
    clkdist_pkg::clk_cfg_s cfg_i = '0;
    logic                  ref_a, ref_b, fab_ref, fixedclk;
    logic                  tx_lock, tx_ser, tx_en, tx_clk, core_clk;
    logic                  rx_det, ovf, chg;
    logic [1:0]            inter_ref;
    logic [3:0]            rx_tr, rx_lock, rx_front, rx_back, rx_clk;
    logic [4:0]            paths;
    int                    fail_count = 0;
    int                    total_checks = 0;
    int                    cyc = 0;

    initial
    begin
        forever #25 clk_i = ~clk_i;
    end

    fabric_model partner (.clk_i(clk_i), .srst_i(srst_i), .ref_a_o(ref_a),
        .ref_b_o(ref_b), .fabric_ref_o(fab_ref), .inter_ref_o(inter_ref),
        .rx_transition_o(rx_tr), .fixedclk_o(fixedclk));

    transceiver_clock_distribution #(.NUM_CH(4)) dut (.clk_i(clk_i),
        .srst_i(srst_i), .ce_i(ce_i), .cfg_i(cfg_i),
        .dedicated_ref_pin_a_i(ref_a), .dedicated_ref_pin_b_i(ref_b),
        .fabric_ref_i(fab_ref), .inter_ref_i(inter_ref),
        .rx_transition_i(rx_tr), .fixedclk_i(fixedclk),
        .tx_pll_locked_o(tx_lock), .tx_serial_clk_o(tx_ser),
        .tx_pcs_clk_en_o(tx_en), .tx_clkout_o(tx_clk),
        .core_clkout_o(core_clk), .rx_pll_locked_o(rx_lock),
        .rx_front_clk_en_o(rx_front), .rx_back_clk_en_o(rx_back),
        .rx_clkout_o(rx_clk), .rx_detect_clk_o(rx_det),
        .route_paths_o(paths), .route_overflow_o(ovf), .cfg_change_o(chg));

    // ==========
    // Helpers
    // ==========
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    // A hang in any wait loop still ends the run with a verdict.
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            results();
        end
    end

    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step

    task automatic start(input clkdist_pkg::clk_cfg_s c);
        cfg_i = c;
        srst_i = 1'b1;
        step(2);
        srst_i = 1'b0;
    endtask : start

    task automatic wait_lock(input int p);
        int n;
        n = 0;
        while (tx_lock !== 1'b1 && n < 200)
        begin
            step(1);
            n++;
        end
        chk_bit(n >= 7 * p && n <= 8 * p + 4, 1'b1);
        step(4);
        chk_val({4'h0, rx_lock}, 8'h0f);
    endtask : wait_lock

    task automatic wait_pulse(output int t);
        int n;
        n = 0;
        do
        begin
            step(1);
            n++;
        end
        while (tx_en !== 1'b1 && n < 60);
        t = cyc;
    endtask : wait_pulse

    // ==========
    // Scenarios
    // ==========
    task automatic run_cfg(input clkdist_pkg::func_mode_e m,
                           input clkdist_pkg::ref_src_e s,
                           input logic idx, input logic core, input int p);
        logic       rm, bs, hi;
        logic [3:0] rx_hi;
        int         ratio, t0, t1, np;
        int         last [4];
        rm = m inside {clkdist_pkg::MODE_PIPE, clkdist_pkg::MODE_GIGE,
                       clkdist_pkg::MODE_XAUI};
        bs = m inside {clkdist_pkg::MODE_PIPE, clkdist_pkg::MODE_XAUI};
        ratio = bs ? 5 : 10;
        np = 2 + (rm ? 0 : 4) + (s == clkdist_pkg::REF_FABRIC);
        np += (m == clkdist_pkg::MODE_PIPE);
        hi = 1'b0;
        rx_hi = 4'h0;
        last = '{-1, -1, -1, -1};
        start('{m, s, idx, core});
        wait_lock(p);
        chk_val({3'h0, paths}, 8'(np));
        chk_bit(ovf, 1'b0);
        wait_pulse(t0);
        wait_pulse(t1);
        chk_val(8'(t1 - t0), 8'((bs ? 4 : 2) * ratio));
        repeat (300)
        begin
            step(1);
            hi |= core ? core_clk : tx_clk;
            chk_bit(core ? tx_clk : core_clk, 1'b0);
            chk_bit(rx_det, rm && bs && !m[1] ? fixedclk : 1'b0);
            for (int k = 0; k < 4; k++)
            begin
                rx_hi[k] |= rx_clk[k];
                chk_bit(rx_back[k], rm ? tx_en : rx_front[k]);
                if (rx_front[k] === 1'b1 && last[k] >= 0)
                    chk_val(8'(cyc - last[k]), 8'(ratio * (k + 1)));
                if (rx_front[k] === 1'b1)
                    last[k] = cyc;
            end
        end
        chk_bit(hi, 1'b1);
        chk_val({4'h0, rx_hi}, rm ? 8'h00 : 8'h0f);
        chk_bit(last[3] >= 0, 1'b1);
    endtask : run_cfg

    task automatic mode_sweep();
        for (int i = 0; i < 5; i++)
            run_cfg(clkdist_pkg::func_mode_e'(3'(i)), clkdist_pkg::REF_PIN_A,
                    1'b0, i[0], 2);
    endtask : mode_sweep

    task automatic ref_sweep();
        for (int i = 1; i < 5; i++)
            run_cfg(clkdist_pkg::func_mode_e'(3'(i)),
                    clkdist_pkg::ref_src_e'(2'(i < 3 ? i : 3)),
                    i == 4, i[0], 2 * i + 2);
    endtask : ref_sweep

    // A live change must be flagged yet leave the running ratio alone.
    task automatic cfg_hold();
        int n;
        start('{clkdist_pkg::MODE_BASIC, clkdist_pkg::REF_PIN_A, 1'b0, 1'b0});
        wait_lock(2);
        chk_bit(chg, 1'b0);
        cfg_i.mode = clkdist_pkg::MODE_XAUI;
        cfg_i.ref_src = clkdist_pkg::REF_PIN_B;
        step(3);
        chk_bit(chg, 1'b1);
        chk_val({3'h0, paths}, 8'h06);
        n = 0;
        repeat (40)
        begin
            step(1);
            n += (rx_front[0] === 1'b1);
        end
        chk_val(8'(n), 8'h04);
        chk_bit(chg, 1'b1);
        start(cfg_i);
        chk_bit(chg, 1'b0);
    endtask : cfg_hold

    task automatic freeze_hold();
        logic s;
        start('{clkdist_pkg::MODE_BASIC, clkdist_pkg::REF_PIN_A, 1'b0, 1'b1});
        wait_lock(2);
        ce_i = 1'b0;
        s = tx_ser;
        repeat (6)
        begin
            step(1);
            chk_bit(tx_ser, s);
        end
        ce_i = 1'b1;
        step(1);
        chk_bit(tx_ser, ~s);
    endtask : freeze_hold

    initial
    begin
        step(2);
        mode_sweep();
        ref_sweep();
        cfg_hold();
        freeze_hold();
        results();
    end
endmodule : test_transceiver_clock_distribution
